// *** verilog/usw_pkg.sv ***
package usw_pkg;

  // ----------------------------------------------------------------
  // Channels and bus
  // ----------------------------------------------------------------
  localparam int CHANNELS   = 2;
  localparam int AXI_ADDR_W = 4;

  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_TIMEOUT = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENUM_BIT   = 0;
  localparam int CTRL_RWU_BIT    = 2;
  localparam int CTRL_PD_BIT     = 3;
  localparam int CTRL_ISO_LSB    = 4;
  localparam int STAT_SETTLE_BIT = 0;
  localparam int STAT_PWR_BIT    = 1;
  localparam int STAT_RESUME_BIT = 2;
  localparam int STAT_FLUSH_LSB  = 4;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMEOUT_RESET = 8'h10;
  localparam logic [7:0] TIMEOUT_MIN   = 8'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int MS_TIME_US      = 1000;
  localparam int SETTLE_TIME_US  = 1000;
  localparam int RST_OUT_TIME_NS = 1000;
  localparam int MS_CYCLES       = MS_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int SETTLE_CYCLES   = SETTLE_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int RST_OUT_CYCLES  =
    (RST_OUT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_CTRL    = 2'b00,
    SEL_TIMEOUT = 2'b01,
    SEL_STATUS  = 2'b10,
    SEL_NONE    = 2'b11
  } usw_sel_t;

endpackage

// *** verilog/usw_strobe_if.sv ***
interface usw_strobe_if #(
  parameter int N = 2
);
  logic [N-1:0] pin_n;
  logic [N-1:0] strobe;

  modport sync (input pin_n, output strobe);
  modport user (output pin_n, input strobe);
endinterface

// *** verilog/usw_wake_sync.sv ***
module usw_wake_sync #(
  parameter int N = 2
) (
  input logic         aclk,
  input logic         aresetn,
  usw_strobe_if.sync  sif
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] strobe;
  } usw_sync_st_t;

  usw_sync_st_t st;
  usw_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = sif.pin_n;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.strobe = st.s3 & ~st.s2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '{s1: '1, s2: '1, s3: '1, strobe: '0};
    end else begin
      st <= next_st;
    end
  end

  assign sif.strobe = st.strobe;

  AST_ONE_SHOT: assert property (@(posedge aclk) disable iff (!aresetn)
    st.strobe[0] |=> !st.strobe[0])
    else $error("wake strobe longer than one cycle");

endmodule

// *** verilog/usw_ctrl.sv ***
// Design decisions made here: the register offsets and the AXI4-Lite register port.
module usw_ctrl #(
  parameter int CH         = usw_pkg::CHANNELS,
  parameter int MS_CYC     = usw_pkg::MS_CYCLES,
  parameter int SETTLE_CYC = usw_pkg::SETTLE_CYCLES
) (
  input  logic                          aclk,
  input  logic                          aresetn,
  input  logic                          reset_in_n,
  output logic                          reset_out_n,
  input  logic [CH-1:0]                 send_now_wake_n,
  input  logic                          usb_suspend,
  input  logic                          usb_bus_reset,
  input  logic [CH-1:0]                 rx_nonempty,
  input  logic [CH-1:0]                 bulk_in_done,
  output logic                          usb_connect_en,
  output logic                          power_enable_n,
  output logic                          io_pulldown_en,
  output logic                          resume_request,
  output logic [CH-1:0]                 flush_request,
  output logic [CH-1:0]                 iso_mode,
  input  logic [usw_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  logic                          s_axi_awvalid,
  output logic                          s_axi_awready,
  input  logic [31:0]                   s_axi_wdata,
  input  logic [3:0]                    s_axi_wstrb,
  input  logic                          s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  logic                          s_axi_bready,
  input  logic [usw_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  logic                          s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  logic                          s_axi_rready
);

  localparam int AW = usw_pkg::AXI_ADDR_W;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic usw_pkg::usw_sel_t reg_sel(input logic [AW-1:0] a);
    usw_pkg::usw_sel_t s;
    s = usw_pkg::SEL_NONE;
    if (a == usw_pkg::ADDR_CTRL) begin
      s = usw_pkg::SEL_CTRL;
    end else if (a == usw_pkg::ADDR_TIMEOUT) begin
      s = usw_pkg::SEL_TIMEOUT;
    end else if (a == usw_pkg::ADDR_STATUS) begin
      s = usw_pkg::SEL_STATUS;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]         settle_cnt;
    logic                settled;
    logic [31:0]         ms_cnt;
    logic                ms_tick;
    logic                enumerated;
    logic                rwu_en;
    logic                pd_cfg;
    logic [CH-1:0]       iso_cfg;
    logic [7:0]          timeout;
    logic [CH-1:0][7:0]  to_cnt;
    logic                resume_pend;
    logic [CH-1:0]       flush_pend;
    logic                pwr_n;
    logic                pd_out;
    logic                aw_hold;
    logic [AW-1:0]       aw_addr;
    logic                w_hold;
    logic [7:0]          w_data;
    logic                w_lane0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [15:0]         rst_cnt;
    logic                rst_out_n;
  } usw_st_t;

  usw_st_t st;
  usw_st_t next_st;

  // ----------------------------------------------------------------
  // Wake pin synchroniser
  // ----------------------------------------------------------------
  usw_strobe_if #(.N(CH)) wake_if ();

  assign wake_if.pin_n = send_now_wake_n;

  usw_wake_sync #(.N(CH)) u_wake_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (wake_if)
  );

  logic [CH-1:0] strobe;
  assign strobe = wake_if.strobe;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic          aw_take;
  logic          w_take;
  logic          wr_go;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  logic          wr_lane0;
  logic          ar_take;

  assign s_axi_awready = !st.aw_hold;
  assign s_axi_wready  = !st.w_hold;
  assign s_axi_arready = !st.rvalid;
  assign aw_take       = s_axi_awvalid && !st.aw_hold;
  assign w_take        = s_axi_wvalid && !st.w_hold;
  assign ar_take       = s_axi_arvalid && !st.rvalid;
  assign wr_go         = (aw_take || st.aw_hold) && (w_take || st.w_hold) && !st.bvalid;
  assign wr_addr       = st.aw_hold ? st.aw_addr : s_axi_awaddr;
  assign wr_data       = st.w_hold ? st.w_data : s_axi_wdata[7:0];
  assign wr_lane0      = st.w_hold ? st.w_lane0 : s_axi_wstrb[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  usw_pkg::usw_sel_t wsel;
  usw_pkg::usw_sel_t rsel;
  logic              wr_ctrl;
  logic              wr_to;
  logic              wr_stat;
  logic [31:0]       ctrl_rd;
  logic [31:0]       stat_rd;
  logic              resume_set;
  logic [CH-1:0]     flush_set;

  always_comb begin
    wsel    = reg_sel(wr_addr);
    rsel    = reg_sel(s_axi_araddr);
    wr_ctrl = wr_go && wr_lane0 && (wsel == usw_pkg::SEL_CTRL);
    wr_to   = wr_go && wr_lane0 && (wsel == usw_pkg::SEL_TIMEOUT);
    wr_stat = wr_go && wr_lane0 && (wsel == usw_pkg::SEL_STATUS);

    ctrl_rd = 32'h0000_0000;
    ctrl_rd[usw_pkg::CTRL_ENUM_BIT] = st.enumerated;
    ctrl_rd[usw_pkg::CTRL_RWU_BIT]  = st.rwu_en;
    ctrl_rd[usw_pkg::CTRL_PD_BIT]   = st.pd_cfg;
    ctrl_rd[usw_pkg::CTRL_ISO_LSB +: CH] = st.iso_cfg;
    stat_rd = 32'h0000_0000;
    stat_rd[usw_pkg::STAT_SETTLE_BIT] = st.settled;
    stat_rd[usw_pkg::STAT_PWR_BIT]    = !st.pwr_n;
    stat_rd[usw_pkg::STAT_RESUME_BIT] = st.resume_pend;
    stat_rd[usw_pkg::STAT_FLUSH_LSB +: CH] = st.flush_pend;

    next_st = st;

    if (!st.settled) begin
      if (st.settle_cnt == 32'(SETTLE_CYC - 1)) begin
        next_st.settled = 1'b1;
      end else begin
        next_st.settle_cnt = st.settle_cnt + 32'h0000_0001;
      end
    end

    // Millisecond enable
    next_st.ms_tick = 1'b0;
    if (st.ms_cnt == 32'(MS_CYC - 1)) begin
      next_st.ms_cnt  = 32'h0000_0000;
      next_st.ms_tick = 1'b1;
    end else begin
      next_st.ms_cnt = st.ms_cnt + 32'h0000_0001;
    end

    // Configuration writes
    if (wr_ctrl) begin
      next_st.enumerated = wr_data[usw_pkg::CTRL_ENUM_BIT] && st.settled;
      next_st.rwu_en     = wr_data[usw_pkg::CTRL_RWU_BIT];
      next_st.pd_cfg     = wr_data[usw_pkg::CTRL_PD_BIT];
      next_st.iso_cfg    = wr_data[usw_pkg::CTRL_ISO_LSB +: CH];
    end
    if (usb_bus_reset) begin
      next_st.enumerated = 1'b0;
    end
    if (wr_to && (wr_data >= usw_pkg::TIMEOUT_MIN)) begin
      next_st.timeout = wr_data;
    end

    resume_set = usb_suspend && st.rwu_en && (|strobe);
    next_st.resume_pend = resume_set ||
      (st.resume_pend && usb_suspend &&
       !(wr_stat && wr_data[usw_pkg::STAT_RESUME_BIT]));

    for (int i = 0; i < CH; i++) begin
      flush_set[i] = strobe[i] && !usb_suspend;
      if (rx_nonempty[i] && !st.flush_pend[i]) begin
        if (st.ms_tick) begin
          if (st.to_cnt[i] + 8'h01 >= st.timeout) begin
            flush_set[i]     = 1'b1;
            next_st.to_cnt[i] = 8'h00;
          end else begin
            next_st.to_cnt[i] = st.to_cnt[i] + 8'h01;
          end
        end
      end else begin
        next_st.to_cnt[i] = 8'h00;
      end
      next_st.flush_pend[i] = flush_set[i] ||
        (st.flush_pend[i] && !bulk_in_done[i] &&
         !(wr_stat && wr_data[usw_pkg::STAT_FLUSH_LSB + i]));
    end

    next_st.pwr_n  = !(next_st.enumerated && !usb_suspend);
    next_st.pd_out = next_st.pd_cfg && next_st.pwr_n;

    // Write channels
    if (aw_take) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_st.w_hold  = 1'b1;
      next_st.w_data  = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = (wsel == usw_pkg::SEL_NONE) ? usw_pkg::RESP_SLVERR
                                                    : usw_pkg::RESP_OKAY;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Read channel
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = usw_pkg::RESP_OKAY;
      unique case (rsel)
        usw_pkg::SEL_CTRL:    next_st.rdata = ctrl_rd;
        usw_pkg::SEL_TIMEOUT: next_st.rdata = {24'h00_0000, st.timeout};
        usw_pkg::SEL_STATUS:  next_st.rdata = stat_rd;
        usw_pkg::SEL_NONE: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = usw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    if (st.rst_cnt != 16'(usw_pkg::RST_OUT_CYCLES)) begin
      next_st.rst_cnt = st.rst_cnt + 16'h0001;
    end
    next_st.rst_out_n = (next_st.rst_cnt == 16'(usw_pkg::RST_OUT_CYCLES));

    // external reset loads reset values into all but the reset stretch and the settle counter and flag
    if (!reset_in_n) begin
      next_st            = '0;
      next_st.timeout    = usw_pkg::TIMEOUT_RESET;
      next_st.pwr_n      = 1'b1;
      next_st.rst_cnt    = st.rst_cnt;
      next_st.rst_out_n  = st.rst_out_n;
      next_st.settle_cnt = st.settle_cnt;
      next_st.settled    = st.settled;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.timeout <= usw_pkg::TIMEOUT_RESET;
      st.pwr_n   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reset_out_n    = st.rst_out_n;
  assign usb_connect_en = st.settled;
  assign power_enable_n = st.pwr_n;
  assign io_pulldown_en = st.pd_out;
  assign resume_request = st.resume_pend;
  assign flush_request  = st.flush_pend;
  assign iso_mode       = st.iso_cfg;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_rvalid   = st.rvalid;
  assign s_axi_rdata    = st.rdata;
  assign s_axi_rresp    = st.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PWR_ON: assert property (@(posedge aclk)
    disable iff (!aresetn || !reset_in_n)
    st.enumerated && !usb_suspend && !usb_bus_reset && !wr_ctrl |=> !power_enable_n)
    else $error("power enable not active after enumeration");

  AST_PWR_OFF: assert property (@(posedge aclk)
    disable iff (!aresetn)
    usb_suspend |=> power_enable_n)
    else $error("power enable active during suspend");

  AST_PULLDOWN: assert property (@(posedge aclk)
    disable iff (!aresetn)
    io_pulldown_en |-> (power_enable_n && st.pd_cfg))
    else $error("pull-down while power is on or not configured");

  AST_RESUME: assert property (@(posedge aclk)
    disable iff (!aresetn || !reset_in_n)
    usb_suspend && st.rwu_en && strobe[0] |=> resume_request)
    else $error("no resume request after wake strobe");

  AST_NO_RESUME: assert property (@(posedge aclk)
    disable iff (!aresetn || !reset_in_n)
    !st.rwu_en && !resume_request |=> !resume_request)
    else $error("resume request without remote wakeup");

  AST_FLUSH: assert property (@(posedge aclk)
    disable iff (!aresetn || !reset_in_n)
    !usb_suspend && strobe[0] |=> flush_request[0] [*1])
    else $error("no flush after wake strobe");

  AST_TIMEOUT_RANGE: assert property (@(posedge aclk)
    disable iff (!aresetn)
    st.timeout >= usw_pkg::TIMEOUT_MIN)
    else $error("buffer timeout out of range");

  AST_EXT_RESET: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !reset_in_n |=> !resume_request && (flush_request == '0) && power_enable_n)
    else $error("external reset did not clear state");

  AST_RST_OUT: assert property (@(posedge aclk)
    !aresetn |=> !reset_out_n [*8])
    else $error("reset output released too early");

  AST_ENUM_GATE: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !usb_connect_en |-> !st.enumerated && power_enable_n)
    else $error("enumerated before clocks settled");

endmodule

// *** dv/usw_host_model.sv ***
module usw_host_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go_suspend,
  input  wire logic       go_bus_reset,
  input  wire logic [1:0] bulk_poll,
  input  wire logic [3:0] bulk_lat,
  output logic            usb_suspend,
  output logic            usb_bus_reset,
  output logic [1:0]      bulk_in_done
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_cnt;

  // ------------------------------------------------
  // Link state and bulk-IN service
  // ------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_suspend   <= 1'b0;
      usb_bus_reset <= 1'b0;
      bulk_in_done  <= 2'b00;
      wait_cnt      <= 4'h0;
    end else begin
      usb_suspend   <= go_suspend;
      usb_bus_reset <= go_bus_reset;
      bulk_in_done  <= 2'b00;
      if (bulk_poll == 2'b00) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == bulk_lat) begin
        bulk_in_done <= bulk_poll;
        wait_cnt     <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// *** dv/tb_usb_suspend_wakeup_flush_ctrl.sv ***
module tb_usb_suspend_wakeup_flush_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic                          aclk;
  logic                          aresetn;
  logic                          reset_in_n;
  logic                          reset_out_n;
  logic [1:0]                    send_now_wake_n;
  logic                          usb_suspend;
  logic                          usb_bus_reset;
  logic [1:0]                    rx_nonempty;
  logic [1:0]                    bulk_in_done;
  logic                          usb_connect_en;
  logic                          power_enable_n;
  logic                          io_pulldown_en;
  logic                          resume_request;
  logic [1:0]                    flush_request;
  logic [1:0]                    iso_mode;
  logic [usw_pkg::AXI_ADDR_W-1:0] s_axi_awaddr;
  logic                          s_axi_awvalid;
  logic                          s_axi_awready;
  logic [31:0]                   s_axi_wdata;
  logic [3:0]                    s_axi_wstrb;
  logic                          s_axi_wvalid;
  logic                          s_axi_wready;
  logic [1:0]                    s_axi_bresp;
  logic                          s_axi_bvalid;
  logic                          s_axi_bready;
  logic [usw_pkg::AXI_ADDR_W-1:0] s_axi_araddr;
  logic                          s_axi_arvalid;
  logic                          s_axi_arready;
  logic [31:0]                   s_axi_rdata;
  logic [1:0]                    s_axi_rresp;
  logic                          s_axi_rvalid;
  logic                          s_axi_rready;
  logic                          go_suspend;
  logic                          go_bus_reset;
  logic [1:0]                    bulk_poll;
  logic [3:0]                    bulk_lat;
  logic [8:0]                    outs;
  int                            n_fail;
  int                            checks;
  int                            cyc;

  assign outs = {reset_out_n, usb_connect_en, power_enable_n, io_pulldown_en,
                 resume_request, flush_request, iso_mode};

  // ------------------------------------------------
  // Design and host model
  // ------------------------------------------------
  usw_ctrl #(.MS_CYC(20), .SETTLE_CYC(16)) usw_ctrl_inst (
    .aclk, .aresetn, .reset_in_n, .reset_out_n, .send_now_wake_n,
    .usb_suspend, .usb_bus_reset, .rx_nonempty, .bulk_in_done,
    .usb_connect_en, .power_enable_n, .io_pulldown_en, .resume_request,
    .flush_request, .iso_mode, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  usw_host_model usw_host_model_inst (
    .aclk, .aresetn, .go_suspend, .go_bus_reset, .bulk_poll, .bulk_lat,
    .usb_suspend, .usb_bus_reset, .bulk_in_done
  );

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_outs(input logic [8:0] e);
    @(negedge aclk);
    chk("outputs", {23'h0, e}, {23'h0, outs});
    @(posedge aclk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic at_cycle(input int n);
    while (cyc < n) @(negedge aclk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       aw_hit;
    logic       w_hit;
    logic       b_hit;
    logic [1:0] resp;
    b_hit = 1'b0;
    resp  = 2'b00;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_hit) begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit  = s_axi_wvalid & s_axi_wready;
      b_hit  = s_axi_bvalid & s_axi_bready;
      resp   = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ar_hit;
    logic        r_hit;
    logic [31:0] data;
    logic [1:0]  resp;
    r_hit = 1'b0;
    data  = 32'h0000_0000;
    resp  = 2'b00;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_hit) begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit  = s_axi_rvalid & s_axi_rready;
      data   = s_axi_rdata;
      resp   = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", ed, data);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic wake_pin(input int ch);
    @(posedge aclk);
    send_now_wake_n[ch] <= 1'b0;
    tick(6);
    send_now_wake_n[ch] <= 1'b1;
    tick(3);
  endtask

  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Clock and timeout
  // ------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    n_fail = 0;
    checks = 0;
    cyc = 0;
    aresetn = 1'b0;
    reset_in_n = 1'b1;
    send_now_wake_n = 2'b11;
    rx_nonempty = 2'b00;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {go_suspend, go_bus_reset, bulk_poll} = '0;
    bulk_lat = 4'h2;
    tick(2);
    aresetn <= 1'b1;
    axi_wr(usw_pkg::ADDR_CTRL, 32'h0000_0001, usw_pkg::RESP_OKAY);
    axi_rd(usw_pkg::ADDR_CTRL, 32'h0000_0000, usw_pkg::RESP_OKAY);
    axi_rd(usw_pkg::ADDR_TIMEOUT, 32'h0000_0010, usw_pkg::RESP_OKAY);
    at_cycle(14);
    expect_outs(9'h040);
    at_cycle(30);
    expect_outs(9'h0c0);
    axi_wr(usw_pkg::ADDR_CTRL, 32'h0000_0009, usw_pkg::RESP_OKAY);
    tick(2);
    expect_outs(9'h080);
    at_cycle(190);
    expect_outs(9'h080);
    at_cycle(215);
    expect_outs(9'h180);
    test_end("reset_and_power");
    go_suspend <= 1'b1;
    tick(4);
    expect_outs(9'h1e0);
    wake_pin(0);
    expect_outs(9'h1e0);
    axi_wr(usw_pkg::ADDR_CTRL, 32'h0000_000d, usw_pkg::RESP_OKAY);
    wake_pin(1);
    expect_outs(9'h1f0);
    axi_rd(usw_pkg::ADDR_STATUS, 32'h0000_0005, usw_pkg::RESP_OKAY);
    go_suspend <= 1'b0;
    tick(4);
    expect_outs(9'h180);
    test_end("suspend_wake");
    for (int i = 3; i >= 0; i--) begin
      axi_wr(usw_pkg::ADDR_CTRL, 32'h0000_0001 | (i << 4), usw_pkg::RESP_OKAY);
      tick(2);
      expect_outs(9'h180 | 9'(i));
    end
    test_end("iso_mode");
    send_now_wake_n[1] <= 1'b0;
    tick(8);
    expect_outs(9'h188);
    axi_rd(usw_pkg::ADDR_STATUS, 32'h0000_0023, usw_pkg::RESP_OKAY);
    bulk_poll <= 2'b10;
    tick(8);
    bulk_poll <= 2'b00;
    tick(6);
    expect_outs(9'h180);
    send_now_wake_n[1] <= 1'b1;
    wake_pin(0);
    expect_outs(9'h184);
    axi_wr(usw_pkg::ADDR_STATUS, 32'h0000_0010, usw_pkg::RESP_OKAY);
    tick(2);
    expect_outs(9'h180);
    test_end("flush");
    axi_wr(usw_pkg::ADDR_TIMEOUT, 32'h0000_0000, usw_pkg::RESP_OKAY);
    axi_rd(usw_pkg::ADDR_TIMEOUT, 32'h0000_0010, usw_pkg::RESP_OKAY);
    axi_wr(usw_pkg::ADDR_TIMEOUT, 32'h0000_0003, usw_pkg::RESP_OKAY);
    rx_nonempty <= 2'b01;
    tick(30);
    expect_outs(9'h180);
    tick(40);
    expect_outs(9'h184);
    rx_nonempty <= 2'b00;
    bulk_poll <= 2'b01;
    tick(6);
    bulk_poll <= 2'b00;
    tick(2);
    expect_outs(9'h180);
    axi_wr(usw_pkg::ADDR_TIMEOUT, 32'h0000_00ff, usw_pkg::RESP_OKAY);
    axi_rd(usw_pkg::ADDR_TIMEOUT, 32'h0000_00ff, usw_pkg::RESP_OKAY);
    test_end("timeout");
    axi_wr(4'hc, 32'h0000_00ff, usw_pkg::RESP_SLVERR);
    axi_rd(4'hc, 32'h0000_0000, usw_pkg::RESP_SLVERR);
    go_bus_reset <= 1'b1;
    tick(1);
    go_bus_reset <= 1'b0;
    tick(4);
    expect_outs(9'h1c0);
    axi_wr(usw_pkg::ADDR_CTRL, 32'h0000_0001, usw_pkg::RESP_OKAY);
    tick(2);
    expect_outs(9'h180);
    reset_in_n <= 1'b0;
    tick(1);
    reset_in_n <= 1'b1;
    tick(2);
    expect_outs(9'h1c0);
    axi_rd(usw_pkg::ADDR_TIMEOUT, 32'h0000_0010, usw_pkg::RESP_OKAY);
    test_end("bus_and_resets");
    test_done();
  end
endmodule
